// File: core/rpc_checker.sv
// region permission checker: region match, permission and type decode, fault record
// assumes one AHB-Lite master, accesses presented as one-cycle requests on the core clock
//
// How it works
// RULE_01: an access not allowed by the region permission at its privilege faults.
// RULE_02: code 000 denies every access at both privilege levels.
// RULE_03: code 001 is privileged read/write only; code 011 is full access.
// RULE_04: code 010 lets unprivileged software read but faults its writes.
// RULE_05: code 101 allows privileged reads only; everything else faults.
// RULE_06: codes 110 and 111 allow reads at both levels, fault all writes.
// RULE_07: type 000 with line hold clear: strongly ordered or device, always shareable.
// RULE_08: type 001 with both flags set is normal write-back allocate memory.
// RULE_09: type top bit set is normal cached; low bits outer, flags inner policy.
// RULE_10: policy values decode 00 none, 01 wb alloc, 10 wt, 11 wb no alloc.
// RULE_11: software should program flash, SRAM and peripherals with the suggested types.
// RULE_12: shareability and cache policy are reported only, never change checking.
// RULE_13: a violation raises the fault and records its cause for software.
// RULE_14: overlapping enabled regions resolve to the highest numbered match.
// RULE_15: background region serves privileged software only; unprivileged misses fault.
// RULE_16: reserved permission code and reserved type combinations deny every access.
// RULE_17: no-fetch regions fault every instruction fetch.
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`default_nettype none
module rpc_checker
    import rpc_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AHB-Lite register slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // access request from the core
    input  wire logic        accValid,
    input  wire rpc_access_s acc,
    // check result, one cycle after the request
    output logic             resValid,
    output logic             memFault,
    output rpc_decode_s      resAttr
);
    ////////////////////////////////////////////////////////////////////////////
    // register slave

    logic                          wrPend_q;
    logic [7:0]                    wrOff_q;
    logic [IDX_W-1:0]              regionSel_q;
    logic                          ctrlEn_q;
    logic [7:0]                    faultCause_q;
    logic [31:0]                   faultAddr_q;
    logic [31:0]                   hrdata_q;
    rpc_region_s [NUM_REGIONS-1:0] regions;
    rpc_decode_s                   dec;
    logic                          faultNow;
    logic                          addrPhase;
    logic                          wrSel;

    assign addrPhase = hsel && hready && htrans == HTRANS_NONSEQ;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign wrSel     = wrPend_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_q <= 1'b0;
            wrOff_q  <= '0;
        end else begin
            wrPend_q <= addrPhase && hwrite && hsize == HSIZE_WORD;
            if (addrPhase) begin
                wrOff_q <= haddr[7:0];
            end
        end
    end

    // read data captured at the address phase, presented in the data phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_q <= '0;
        end else if (addrPhase && !hwrite) begin
            case (haddr[7:0])
                OFF_REGION_SEL:  hrdata_q <= 32'(regionSel_q);
                OFF_REGION_BASE: hrdata_q <= regions[regionSel_q].base;
                OFF_REGION_ATTR: hrdata_q <= regions[regionSel_q].attr;
                OFF_CTRL:        hrdata_q <= 32'(ctrlEn_q);
                OFF_FAULT_CAUSE: hrdata_q <= 32'(faultCause_q);
                OFF_FAULT_ADDR:  hrdata_q <= faultAddr_q;
                OFF_LAST_ATTR:   hrdata_q <= 32'(resAttr);
                default:         hrdata_q <= '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regionSel_q <= '0;
            ctrlEn_q    <= 1'b0;
        end else if (wrSel) begin
            if (wrOff_q == OFF_REGION_SEL) begin
                regionSel_q <= hwdata[IDX_W-1:0];
            end
            if (wrOff_q == OFF_CTRL) begin
                ctrlEn_q <= hwdata[CTRL_EN];
            end
        end
    end

    rpc_region_store rpc_region_store_i (
        .clk     (clk),
        .rst_n   (rst_n),
        .baseWe  (wrSel && wrOff_q == OFF_REGION_BASE),
        .attrWe  (wrSel && wrOff_q == OFF_REGION_ATTR),
        .wrIdx   (regionSel_q),
        .wrData  (hwdata),
        .regions (regions)
    );

    ////////////////////////////////////////////////////////////////////////////
    // region match and priority

    logic [NUM_REGIONS-1:0] hits;
    logic [IDX_W-1:0]       selIdx;
    logic                   hitAny;
    logic [31:0]            attr;

    for (genvar i = 0; i < NUM_REGIONS; i++) begin : g_match
        logic [31:0] mask;
        assign mask    = 32'hffffffff << (6'(regions[i].attr[ATTR_SIZE_H:ATTR_SIZE_L]) + 6'd1);
        assign hits[i] = regions[i].attr[ATTR_EN] && ((acc.addr ^ regions[i].base) & mask) == '0;
    end

    always_comb begin
        selIdx = '0;
        hitAny = 1'b0;
        for (int i = 0; i < NUM_REGIONS; i++) begin
            if (hits[i]) begin
                selIdx = IDX_W'(i); // RULE_14
                hitAny = 1'b1;
            end
        end
    end

    assign attr = regions[selIdx].attr;

    ////////////////////////////////////////////////////////////////////////////
    // attribute decode

    logic [2:0] memType;
    logic [2:0] perm;
    logic       lineHold;
    logic       wrMerge;
    logic       poolWide;
    logic       noFetch;
    logic       permOk;
    logic       isWrite;

    assign memType  = attr[ATTR_TYPE_H:ATTR_TYPE_L];
    assign perm     = attr[ATTR_PERM_H:ATTR_PERM_L];
    assign lineHold = attr[ATTR_LHOLD];
    assign wrMerge  = attr[ATTR_WMERGE];
    assign poolWide = attr[ATTR_POOL];
    assign noFetch  = attr[ATTR_NOFET];
    assign isWrite  = acc.write && !acc.fetch;

    // shareability and policy only feed the report, never the fault
    always_comb begin
        dec           = '0;
        dec.hit       = hitAny;
        dec.region    = selIdx;
        dec.kind      = MEM_RESERVED;
        dec.shareable = poolWide; // RULE_12
        dec.outer     = POL_NONCACHE;
        dec.inner     = POL_NONCACHE;
        if (memType[TYPE_CACHED]) begin
            dec.kind  = MEM_NORMAL; // RULE_09
            dec.outer = rpc_policy_e'(memType[1:0]); // RULE_10
            dec.inner = rpc_policy_e'({lineHold, wrMerge});
        end else begin
            case (memType)
                TYPE_BASIC: begin
                    if (!lineHold) begin
                        dec.kind      = wrMerge ? MEM_DEVICE : MEM_STRONG; // RULE_07
                        dec.shareable = 1'b1;
                    end else begin
                        dec.kind  = MEM_NORMAL;
                        dec.outer = wrMerge ? POL_WB_NWA : POL_WT_NWA;
                        dec.inner = dec.outer;
                    end
                end
                TYPE_NORMAL: begin
                    if (lineHold && wrMerge) begin
                        dec.kind  = MEM_NORMAL; // RULE_08
                        dec.outer = POL_WB_RWA;
                        dec.inner = POL_WB_RWA;
                    end else if (!lineHold && !wrMerge) begin
                        dec.kind = MEM_NORMAL;
                    end
                end
                TYPE_DEVICE: begin
                    if (!lineHold && !wrMerge) begin
                        dec.kind      = MEM_DEVICE;
                        dec.shareable = 1'b0;
                    end
                end
                default: dec.kind = MEM_RESERVED;
            endcase
        end
        if (!hitAny) begin
            dec.kind = MEM_RESERVED;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // permission check

    always_comb begin
        case (perm)
            PERM_NONE:    permOk = 1'b0; // RULE_02
            PERM_PRIV_RW: permOk = acc.priv; // RULE_03
            PERM_USER_RO: permOk = acc.priv || !isWrite; // RULE_04
            PERM_FULL:    permOk = 1'b1; // RULE_03
            PERM_PRIV_RO: permOk = acc.priv && !isWrite; // RULE_05
            PERM_RO_A:    permOk = !isWrite; // RULE_06
            PERM_RO_B:    permOk = !isWrite; // RULE_06
            default:      permOk = 1'b0; // RULE_16
        endcase
    end

    always_comb begin
        faultNow = 1'b0;
        if (accValid && ctrlEn_q) begin
            if (hitAny) begin
                faultNow = !permOk || dec.kind == MEM_RESERVED || (acc.fetch && noFetch); // RULE_01 RULE_16 RULE_17
            end else begin
                faultNow = !acc.priv; // RULE_15
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result and fault record

    logic        resValid_q;
    logic        memFault_q;
    rpc_decode_s resAttr_q;
    logic [7:0]  causeSet;
    logic [7:0]  causeClr;

    assign resValid = resValid_q;
    assign memFault = memFault_q;
    assign resAttr  = resAttr_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resValid_q <= 1'b0;
            memFault_q <= 1'b0;
            resAttr_q  <= '0;
        end else begin
            resValid_q <= accValid;
            memFault_q <= faultNow; // RULE_13
            if (accValid) begin
                resAttr_q <= dec;
            end
        end
    end

    always_comb begin
        causeSet = '0;
        if (faultNow) begin
            causeSet[CAUSE_FETCH]    = acc.fetch;
            causeSet[CAUSE_DATA]     = !acc.fetch;
            causeSet[CAUSE_ADDR_VLD] = !acc.fetch;
        end
        causeClr = (wrSel && wrOff_q == OFF_FAULT_CAUSE) ? hwdata[7:0] : '0;
    end

    // write one to clear; a new fault in the same cycle wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faultCause_q <= CAUSE_RESET;
            faultAddr_q  <= '0;
        end else begin
            faultCause_q <= (faultCause_q & ~causeClr) | causeSet; // RULE_13
            if (faultNow && !acc.fetch) begin
                faultAddr_q <= acc.addr;
            end else if (wrSel && wrOff_q == OFF_FAULT_ADDR) begin
                faultAddr_q <= hwdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic chk;
    assign chk = accValid && ctrlEn_q && hitAny;

    zero_perm_a: assert property (chk && perm == PERM_NONE |=> memFault) // RULE_02
        else $error("code 000 access did not fault");
    priv_only_a: assert property (chk && perm == PERM_PRIV_RW && !acc.priv |=> memFault) // RULE_03
        else $error("unprivileged access to privileged region passed");
    full_access_a: assert property (chk && perm == PERM_FULL && dec.kind != MEM_RESERVED && !noFetch // RULE_03
                                    |=> !memFault)
        else $error("full access region faulted");
    user_write_a: assert property (chk && perm == PERM_USER_RO && !acc.priv && isWrite |=> memFault) // RULE_04
        else $error("unprivileged write to user read-only passed");
    priv_read_a: assert property (chk && perm == PERM_PRIV_RO && (isWrite || !acc.priv) |=> memFault) // RULE_05
        else $error("privileged read-only region allowed other access");
    read_only_a: assert property (chk && perm[2:1] == PERM_RO_A[2:1] && isWrite |=> memFault) // RULE_06
        else $error("write to read-only region passed");
    strong_share_a: assert property (accValid && hitAny && memType == TYPE_BASIC && !lineHold // RULE_07
                                     |=> resAttr.shareable && resAttr.kind != MEM_NORMAL)
        else $error("basic type not decoded as shareable ordered memory");
    wb_alloc_a: assert property (accValid && hitAny && memType == TYPE_NORMAL && lineHold && wrMerge // RULE_08
                                 |=> resAttr.kind == MEM_NORMAL && resAttr.inner == POL_WB_RWA)
        else $error("normal write-back type decoded wrongly");
    cached_pol_a: assert property (accValid && hitAny && memType[TYPE_CACHED] // RULE_09
                                   |=> resAttr.outer == $past(memType[1:0]))
        else $error("outer policy not taken from type bits");
    reserved_a: assert property (chk && (perm == PERM_RSVD || dec.kind == MEM_RESERVED) |=> memFault) // RULE_16
        else $error("reserved encoding access passed");
    no_fetch_a: assert property (chk && acc.fetch && noFetch |=> memFault ##0 faultCause_q[CAUSE_FETCH]) // RULE_17
        else $error("fetch from no-fetch region passed");
    background_a: assert property (accValid && ctrlEn_q && !hitAny |=> memFault == !$past(acc.priv)) // RULE_15
        else $error("background region privilege wrong");
    cause_rec_a: assert property (memFault |-> faultCause_q != CAUSE_RESET) // RULE_13
        else $error("fault without recorded cause");
    top_region_a: assert property (hitAny |-> (hits >> selIdx) == NUM_REGIONS'(1)) // RULE_14
        else $error("lower region chosen over higher match");

    fault_seen_c: cover property (memFault ##1 wrSel && wrOff_q == OFF_FAULT_CAUSE);
    overlap_c: cover property (accValid && $countones(hits) > 1);
    user_ok_c: cover property (chk && !acc.priv && !faultNow);
    bg_priv_c: cover property (accValid && ctrlEn_q && !hitAny && acc.priv);
endmodule
`default_nettype wire

// File: core/rpc_region_store.sv
// storage of base and attribute words for all protection regions
// assumes writes come from the register slave, one word per cycle
`default_nettype none
module rpc_region_store
    import rpc_pkg::*;
(
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // write port
    input  wire logic                          baseWe,
    input  wire logic                          attrWe,
    input  wire logic [IDX_W-1:0]              wrIdx,
    input  wire logic [31:0]                   wrData,
    // all entries, straight from flops
    output rpc_region_s [NUM_REGIONS-1:0]      regions
);
    for (genvar i = 0; i < NUM_REGIONS; i++) begin : g_entry
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                regions[i] <= '0;
            end else begin
                if (baseWe && wrIdx == IDX_W'(i)) begin
                    regions[i].base <= wrData;
                end
                if (attrWe && wrIdx == IDX_W'(i)) begin
                    regions[i].attr <= wrData & ATTR_WR_MASK;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: include/rpc_pkg.sv
// constants, types and register map of the region permission checker
// assumes a single 250 MHz core clock domain and an AHB-Lite register port
`default_nettype none
package rpc_pkg;
    localparam int NUM_REGIONS = 8;
    localparam int IDX_W       = 3;

    // register byte offsets
    localparam logic [7:0] OFF_REGION_SEL  = 8'h00;
    localparam logic [7:0] OFF_REGION_BASE = 8'h04;
    localparam logic [7:0] OFF_REGION_ATTR = 8'h08;
    localparam logic [7:0] OFF_CTRL        = 8'h0c;
    localparam logic [7:0] OFF_FAULT_CAUSE = 8'h10;
    localparam logic [7:0] OFF_FAULT_ADDR  = 8'h14;
    localparam logic [7:0] OFF_LAST_ATTR   = 8'h18;

    // region_attribute_register fields
    localparam int ATTR_EN     = 0;
    localparam int ATTR_SIZE_L = 1;
    localparam int ATTR_SIZE_H = 5;
    localparam int ATTR_WMERGE = 16;
    localparam int ATTR_LHOLD  = 17;
    localparam int ATTR_POOL   = 18;
    localparam int ATTR_TYPE_L = 19;
    localparam int ATTR_TYPE_H = 21;
    localparam int ATTR_PERM_L = 24;
    localparam int ATTR_PERM_H = 26;
    localparam int ATTR_NOFET  = 28;
    localparam logic [31:0] ATTR_WR_MASK = 32'h173f003f;

    // control and fault cause bits
    localparam int CTRL_EN        = 0;
    localparam int CAUSE_FETCH    = 0;
    localparam int CAUSE_DATA     = 1;
    localparam int CAUSE_ADDR_VLD = 7;
    localparam logic [7:0] CAUSE_RESET = 8'h00;

    // permission codes
    localparam logic [2:0] PERM_NONE    = 3'b000;
    localparam logic [2:0] PERM_PRIV_RW = 3'b001;
    localparam logic [2:0] PERM_USER_RO = 3'b010;
    localparam logic [2:0] PERM_FULL    = 3'b011;
    localparam logic [2:0] PERM_RSVD    = 3'b100;
    localparam logic [2:0] PERM_PRIV_RO = 3'b101;
    localparam logic [2:0] PERM_RO_A    = 3'b110;
    localparam logic [2:0] PERM_RO_B    = 3'b111;

    // memory type field values
    localparam logic [2:0] TYPE_BASIC  = 3'b000;
    localparam logic [2:0] TYPE_NORMAL = 3'b001;
    localparam logic [2:0] TYPE_DEVICE = 3'b010;
    localparam int         TYPE_CACHED = 2;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD    = 3'b010;

    typedef enum logic [1:0] {MEM_STRONG, MEM_DEVICE, MEM_NORMAL, MEM_RESERVED} rpc_kind_e;
    // order follows the two-bit policy encoding 00..11
    typedef enum logic [1:0] {POL_NONCACHE, POL_WB_RWA, POL_WT_NWA, POL_WB_NWA} rpc_policy_e;

    typedef struct packed {
        logic [31:0] base;
        logic [31:0] attr;
    } rpc_region_s;

    typedef struct packed {
        logic [31:0] addr;
        logic        write;
        logic        fetch;
        logic        priv;
    } rpc_access_s;

    typedef struct packed {
        logic        hit;
        logic [2:0]  region;
        rpc_kind_e   kind;
        logic        shareable;
        rpc_policy_e outer;
        rpc_policy_e inner;
    } rpc_decode_s;
endpackage
`default_nettype wire

// File: verification/rpc_checker_tb.sv
// self-checking bench for the region permission checker
// assumes a zero-wait register slave and one-cycle access latency
`default_nettype none
module rpc_checker_tb
    import rpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, accValid, resValid, memFault;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    rpc_access_s acc;
    rpc_decode_s resAttr;
    int          errTotal, checksDone;

    assign hready = hreadyout;

    rpc_checker rpc_checker_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .accValid(accValid), .acc(acc), .resValid(resValid),
        .memFault(memFault), .resAttr(resAttr));

    rpc_core_model rpc_core_model_i (.clk(clk), .rst_n(rst_n), .accValid(accValid), .acc(acc),
        .resValid(resValid), .memFault(memFault), .resAttr(resAttr));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] off, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize  <= HSIZE_WORD;
        haddr  <= {24'h0, off};
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        chk("response", 32'h0, {31'h0, hresp});
    endtask

    task automatic wrReg(input logic [7:0] off, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, off, d, r);
    endtask

    function automatic logic [31:0] mkAttr(input logic [2:0] p, ty, input logic s, c, b, nf, input logic [4:0] sz);
        logic [31:0] a;
        a = 32'h1;
        a[ATTR_SIZE_H:ATTR_SIZE_L] = sz;
        a[ATTR_WMERGE] = b;
        a[ATTR_LHOLD] = c;
        a[ATTR_POOL] = s;
        a[ATTR_TYPE_H:ATTR_TYPE_L] = ty;
        a[ATTR_PERM_H:ATTR_PERM_L] = p;
        a[ATTR_NOFET] = nf;
        return a;
    endfunction

    task automatic setRegion(input logic [2:0] idx, p, ty, input logic s, c, b, nf, input logic [4:0] sz);
        wrReg(OFF_REGION_SEL, {29'h0, idx});
        wrReg(OFF_REGION_BASE, 32'h2000_0000);
        wrReg(OFF_REGION_ATTR, mkAttr(p, ty, s, c, b, nf, sz));
    endtask

    function automatic logic permFault(input logic [2:0] p, input logic pv, wr);
        case (p)
            PERM_PRIV_RW:         return !pv;
            PERM_USER_RO:         return !pv && wr;
            PERM_FULL:            return 1'b0;
            PERM_PRIV_RO:         return !pv || wr;
            PERM_RO_A, PERM_RO_B: return wr;
            default:              return 1'b1;
        endcase
    endfunction

    task automatic access(input logic [31:0] a, input logic wr, fe, pv, ef, output rpc_decode_s at);
        logic vld, flt;
        rpc_core_model_i.doAcc({a, wr, fe, pv}, vld, flt, at);
        chk("result valid", 32'h1, {31'h0, vld});
        chk("fault", {31'h0, ef}, {31'h0, flt});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic testReset();
        logic [31:0] r;
        chk("fault idle", 32'h0, {30'h0, resValid, memFault});
        bus(1'b0, OFF_FAULT_CAUSE, 32'h0, r);
        chk("cause reset", {24'h0, CAUSE_RESET}, r);
        bus(1'b0, 8'h1c, 32'h0, r);
        chk("unmapped", 32'h0, r);
    endtask

    task automatic testDisabled();
        rpc_decode_s at;
        access(32'h4000_0000, 1'b1, 1'b0, 1'b0, 1'b0, at);
        wrReg(OFF_CTRL, 32'h1);
    endtask

    task automatic testPerm();
        rpc_decode_s at;
        logic [31:0] r;
        for (int p = 0; p < 8; p++) begin
            setRegion(3'h0, 3'(p), TYPE_NORMAL, 1'b0, 1'b1, 1'b1, 1'b0, 5'd15);
            for (int k = 0; k < 4; k++) begin
                access(32'h2000_8000, k[1], 1'b0, k[0], permFault(3'(p), k[0], k[1]), at);
            end
        end
        bus(1'b0, OFF_REGION_ATTR, 32'h0, r);
        chk("attr", mkAttr(PERM_RO_B, TYPE_NORMAL, 1'b0, 1'b1, 1'b1, 1'b0, 5'd15) & ATTR_WR_MASK, r);
    endtask

    task automatic typeCase(input logic [2:0] ty, input logic s, c, b, ef, input rpc_kind_e k, input logic sh,
                            input logic [3:0] pol, input logic cp);
        rpc_decode_s at;
        setRegion(3'h0, PERM_FULL, ty, s, c, b, 1'b0, 5'd15);
        access(32'h2000_8000, 1'b1, 1'b0, 1'b1, ef, at);
        if (!ef) begin
            chk("kind", {30'h0, k}, {30'h0, at.kind});
            chk("shareable", {31'h0, sh}, {31'h0, at.shareable});
            if (cp)
                chk("policy", {28'h0, pol}, {28'h0, at.outer, at.inner});
        end
    endtask

    task automatic testTypes();
        typeCase(3'b000, 0, 0, 0, 0, MEM_STRONG, 1, 4'h0, 0);
        typeCase(3'b000, 1, 0, 1, 0, MEM_DEVICE, 1, 4'h0, 0);
        typeCase(3'b000, 0, 1, 0, 0, MEM_NORMAL, 0, {POL_WT_NWA, POL_WT_NWA}, 1);
        typeCase(3'b000, 1, 1, 0, 0, MEM_NORMAL, 1, {POL_WT_NWA, POL_WT_NWA}, 1);
        typeCase(3'b000, 1, 1, 1, 0, MEM_NORMAL, 1, {POL_WB_NWA, POL_WB_NWA}, 1);
        typeCase(3'b001, 1, 1, 1, 0, MEM_NORMAL, 1, {POL_WB_RWA, POL_WB_RWA}, 1);
        typeCase(3'b001, 0, 1, 1, 0, MEM_NORMAL, 0, {POL_WB_RWA, POL_WB_RWA}, 1);
        typeCase(3'b101, 1, 1, 0, 0, MEM_NORMAL, 1, {POL_WB_RWA, POL_WT_NWA}, 1);
        typeCase(3'b110, 0, 0, 0, 0, MEM_NORMAL, 0, {POL_WT_NWA, POL_NONCACHE}, 1);
        typeCase(3'b111, 0, 1, 1, 0, MEM_NORMAL, 0, {POL_WB_NWA, POL_WB_NWA}, 1);
        typeCase(3'b010, 0, 0, 0, 0, MEM_DEVICE, 0, 4'h0, 0);
        typeCase(3'b001, 0, 0, 1, 1, MEM_RESERVED, 0, 4'h0, 0);
        typeCase(3'b010, 0, 1, 0, 1, MEM_RESERVED, 0, 4'h0, 0);
        typeCase(3'b011, 0, 0, 0, 1, MEM_RESERVED, 0, 4'h0, 0);
    endtask

    task automatic testFaultRecord();
        rpc_decode_s at;
        logic [31:0] r;
        setRegion(3'h0, PERM_FULL, TYPE_NORMAL, 1'b0, 1'b1, 1'b1, 1'b1, 5'd15);
        wrReg(OFF_FAULT_CAUSE, 32'hff);
        access(32'h2000_8000, 1'b0, 1'b1, 1'b1, 1'b1, at);
        bus(1'b0, OFF_FAULT_CAUSE, 32'h0, r);
        chk("fetch cause", 32'(1 << CAUSE_FETCH), r);
        access(32'h2000_8004, 1'b0, 1'b0, 1'b0, 1'b0, at);
        setRegion(3'h0, PERM_NONE, TYPE_NORMAL, 1'b0, 1'b1, 1'b1, 1'b0, 5'd15);
        wrReg(OFF_FAULT_CAUSE, 32'hff);
        access(32'h2000_8010, 1'b1, 1'b0, 1'b1, 1'b1, at);
        bus(1'b0, OFF_FAULT_CAUSE, 32'h0, r);
        chk("data cause", 32'(1 << CAUSE_DATA | 1 << CAUSE_ADDR_VLD), r);
        bus(1'b0, OFF_FAULT_ADDR, 32'h0, r);
        chk("fault addr", 32'h2000_8010, r);
        wrReg(OFF_FAULT_CAUSE, 32'hff);
        bus(1'b0, OFF_FAULT_CAUSE, 32'h0, r);
        chk("cause cleared", 32'h0, r);
    endtask

    task automatic testOverlap();
        rpc_decode_s at;
        setRegion(3'h0, PERM_FULL, TYPE_NORMAL, 1'b0, 1'b1, 1'b1, 1'b0, 5'd15);
        setRegion(3'h1, PERM_NONE, TYPE_NORMAL, 1'b0, 1'b1, 1'b1, 1'b0, 5'd9);
        access(32'h2000_0100, 1'b0, 1'b0, 1'b1, 1'b1, at);
        chk("region", 32'h1, {29'h0, at.region});
        access(32'h2000_8000, 1'b0, 1'b0, 1'b1, 1'b0, at);
        chk("region", 32'h0, {29'h0, at.region});
        access(32'h4000_0000, 1'b0, 1'b0, 1'b1, 1'b0, at);
        chk("hit", 32'h0, {31'h0, at.hit});
        access(32'h4000_0000, 1'b0, 1'b0, 1'b0, 1'b1, at);
    endtask

    task automatic closeOut();
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        errTotal++;
        closeOut();
    end

    initial begin
        rst_n  = 1'b0;
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = 3'h0;
        hwdata = 32'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        testReset();
        testDisabled();
        testPerm();
        testTypes();
        testFaultRecord();
        testOverlap();
        closeOut();
    end
endmodule
`default_nettype wire

// File: verification/rpc_core_model.sv
// core-side model: issues one access and collects the check result
// assumes the checker answers one cycle after the request edge
`default_nettype none
module rpc_core_model
    import rpc_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // request to the checker
    output var logic         accValid,
    output var rpc_access_s  acc,
    // result from the checker
    input  wire logic        resValid,
    input  wire logic        memFault,
    input  wire rpc_decode_s resAttr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        accValid = 1'b0;
        acc      = '0;
    end

    // request stands for one edge, then the lines are scrambled
    task automatic doAcc(input rpc_access_s a, output logic vld, output logic flt, output rpc_decode_s at);
        @(posedge clk);
        accValid <= 1'b1;
        acc      <= a;
        @(posedge clk);
        accValid <= 1'b0;
        acc      <= ~a;
        @(posedge clk);
        vld = resValid;
        flt = memFault;
        at  = resAttr;
    endtask
endmodule
`default_nettype wire
